// ===== verilog/sgp_driver.sv
// Serial grayscale PWM driver: shift chain, display latch and PWM core
`timescale 1ns/100ps
`include "sgp_cfg.svh"

// Operation
// [R1] Each rising shift clock edge shifts serial_in into the chain toward the MSB.
// [R2] The chain MSB reaches serial_out through a stage updated on the falling shift clock edge.
// [R3] The controller leaves at least 100 ns after a latch rise before the next shift clock rise.
// [R4] A latch rise copies the whole chain into the display latch.
// [R5] After a latch rise all sinks stay off until the next display period begins.
// [R6] A latch rise leaves the grayscale counter running from its present value.
// [R7] While blanking is high all sinks are off, timing is reinitialised and the counter is zero.
// [R8] While blanking is low each sink follows the PWM timing and its latched value.
// [R9] Turn-on is staggered in four groups by channel index modulo four, about 24, 48, 72 ns apart; the code uses 20, 40, 60 ns (1, 2, 3 mclk cycles).
// [R10] The chain holds 24 fields of 12 bits, MSB first, highest channel at the MSB end.
// [R11] The counter steps at about 4 MHz, wraps after 4096, and a sink is on while below its value.
module sgp_driver (
  input wire logic mclk, // System clock, 50 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic shift_clock, // Serial shift clock from the controller
  input wire logic serial_in, // Serial grayscale data
  input wire logic latch_strobe, // Latch strobe, rising edge acts
  input wire logic output_blanking, // High forces all sinks off
  output logic serial_out, // Cascade data
  output logic [`SGP_CH-1:0] sink_output // Sink enables, high = on
);
  // Stagger delays in whole mclk cycles, rounded down, group 0 none, group 1 at least one
  localparam int G1C = (`SGP_GRP1_NS / `SGP_MCLK_NS) < 1 ? 1 : (`SGP_GRP1_NS / `SGP_MCLK_NS);
  localparam int G2C = `SGP_GRP2_NS / `SGP_MCLK_NS;
  localparam int G3C = `SGP_GRP3_NS / `SGP_MCLK_NS;
  localparam logic [3:0][`SGP_STAGW-1:0] DLY = {
    `SGP_STAGW'(G3C), `SGP_STAGW'(G2C), `SGP_STAGW'(G1C), `SGP_STAGW'(0)
  };
  localparam int FW = $bits(sgp_pkg::sgp_word_t);

  sgp_pkg::sgp_link_t link_q;
  sgp_pkg::sgp_link_t link_d;
  logic serial_out_q;
  sgp_pkg::sgp_core_t core_q;
  sgp_pkg::sgp_core_t core_d;

  logic xl_rise;
  logic per_start;
  logic [`SGP_CH-1:0] on_w;
  logic push_valid;
  logic push_ready;
  sgp_pkg::sgp_word_t push_word;
  logic pop_valid;
  logic pop_ready;
  sgp_pkg::sgp_word_t pop_word;

  // ---- Shift clock domain ----

  // Shift chain; channel 23 field ends up at the top
  always_comb begin
    link_d = link_q;
    link_d.shreg = {link_q.shreg[`SGP_SRW-2:0], serial_in}; // [R1] [R10]
  end

  always_ff @(posedge shift_clock or negedge nrst) begin
    if (!nrst) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // Falling-edge stage gives the next device a full half period of margin
  always_ff @(negedge shift_clock or negedge nrst) begin
    if (!nrst) begin
      serial_out_q <= 1'b0;
    end else begin
      serial_out_q <= link_q.shreg[`SGP_SRW-1]; // [R2]
    end
  end

  assign serial_out = serial_out_q;

  // ---- mclk domain ----

  assign xl_rise = core_q.xl_s2 && !core_q.xl_s3;
  assign per_start = core_q.tick && (core_q.cnt == `SGP_CNT_MAX);

  // Per-channel PWM compare with group stagger
  genvar gi;
  generate
    for (gi = 0; gi < `SGP_CH; gi++) begin : g_ch
      assign on_w[gi] = (core_q.cnt < core_q.gs[gi]) && (core_q.stag >= DLY[gi % 4]); // [R8] [R9] [R11]
    end
  endgenerate

  // Loader offers one field per cycle to the FIFO and advances only while the FIFO has room
  assign push_valid = (core_q.ld == sgp_pkg::SGP_LOAD) && !xl_rise;
  assign push_word.ch = core_q.idx;
  assign push_word.gs = core_q.snap[core_q.idx];

  // Drain one word per oscillator tick; while blanked drain every cycle,
  // since ticks stop then and a pending load would otherwise never land
  assign pop_ready = core_q.tick || core_q.bk_s2;

  // Loader runs ahead of the slow drain, so the FIFO fills up
  sgp_fifo #(
    .W(FW),
    .DEPTH(`SGP_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_word)
  );

  // Next state of the core
  always_comb begin
    core_d = core_q;
    // Two-stage synchronisers for the strobe pins
    core_d.xl_s1 = latch_strobe;
    core_d.xl_s2 = core_q.xl_s1;
    core_d.xl_s3 = core_q.xl_s2;
    core_d.bk_s1 = output_blanking;
    core_d.bk_s2 = core_q.bk_s1;

    // Chain is quiet for 100 ns after the strobe, longer than the sync delay
    if (xl_rise) begin
      core_d.snap = link_q.shreg; // [R3] [R4]
    end

    // Loader state machine
    case (core_q.ld)
      sgp_pkg::SGP_IDLE: begin
        if (xl_rise) begin
          core_d.ld = sgp_pkg::SGP_LOAD;
          core_d.idx = '0;
        end
      end
      sgp_pkg::SGP_LOAD: begin
        if (xl_rise) begin
          core_d.idx = '0;
        end else if (push_ready) begin
          if (core_q.idx == `SGP_LAST_CH) begin
            core_d.ld = sgp_pkg::SGP_IDLE;
          end else begin
            core_d.idx = core_q.idx + 1'b1;
          end
        end
      end
      default: begin
        core_d.ld = sgp_pkg::SGP_IDLE;
      end
    endcase

    // Display latch written from the FIFO head
    if (pop_valid && pop_ready) begin
      core_d.gs[pop_word.ch] = pop_word.gs; // [R4]
    end

    // Fractional divider approximates the 4 MHz oscillator
    core_d.tick = 1'b0;
    if (core_q.acc + `SGP_ACCW'(`SGP_OSC_KHZ) >= `SGP_ACCW'(`SGP_MCLK_KHZ)) begin
      core_d.acc = core_q.acc + `SGP_ACCW'(`SGP_OSC_KHZ) - `SGP_ACCW'(`SGP_MCLK_KHZ);
      core_d.tick = 1'b1;
    end else begin
      core_d.acc = core_q.acc + `SGP_ACCW'(`SGP_OSC_KHZ);
    end

    // Counter wraps by width; the strobe does not touch it
    if (core_q.tick) begin
      core_d.cnt = core_q.cnt + 1'b1; // [R6] [R11]
    end

    // Hold after a strobe; the set wins over a clear in the same cycle
    if (xl_rise) begin
      core_d.hold = 1'b1; // [R5]
    end else if (per_start && core_q.ld == sgp_pkg::SGP_IDLE && !pop_valid) begin
      core_d.hold = 1'b0; // [R5]
    end

    // Stagger timer restarts at each period start
    if (per_start) begin
      core_d.stag = '0; // [R9]
    end else if (core_q.stag < DLY[3]) begin
      core_d.stag = core_q.stag + 1'b1;
    end

    core_d.sink = core_q.hold ? '0 : on_w; // [R5] [R8]

    // Blanking overrides the timing and the counter
    if (core_q.bk_s2) begin
      core_d.cnt = '0; // [R7]
      core_d.acc = '0;
      core_d.tick = 1'b0;
      core_d.stag = '0;
      core_d.hold = xl_rise || (core_q.ld == sgp_pkg::SGP_LOAD) || pop_valid; // [R4] [R5]
      core_d.sink = '0; // [R7]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      core_q <= '0;
      core_q.ld <= sgp_pkg::SGP_IDLE;
    end else begin
      core_q <= core_d;
    end
  end

  assign sink_output = core_q.sink;

  // ---- Checks ----

  property p_shift;
    @(posedge shift_clock) disable iff (!nrst)
    1'b1 |=> link_q.shreg[`SGP_SRW-1:1] == $past(link_q.shreg[`SGP_SRW-2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("chain did not shift by one"); // [R1]

  property p_serial_out;
    @(negedge shift_clock) disable iff (!nrst)
    1'b1 |=> serial_out == $past(link_q.shreg[`SGP_SRW-1]);
  endproperty
  a_serial_out: assert property (p_serial_out) else $error("serial_out not MSB of last fall"); // [R2]

  property p_latch;
    @(posedge mclk) disable iff (!nrst)
    xl_rise |=> core_q.snap == $past(link_q.shreg) && core_q.ld == sgp_pkg::SGP_LOAD;
  endproperty
  a_latch: assert property (p_latch) else $error("latch did not capture chain"); // [R4]

  property p_hold;
    @(posedge mclk) disable iff (!nrst)
    xl_rise |-> ##2 (sink_output == '0) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("sink on right after latch"); // [R5]

  property p_count;
    @(posedge mclk) disable iff (!nrst)
    xl_rise && !core_q.bk_s2 && !core_q.tick |=> core_q.cnt == $past(core_q.cnt);
  endproperty
  a_count: assert property (p_count) else $error("latch disturbed counter"); // [R6]

  property p_blank;
    @(posedge mclk) disable iff (!nrst)
    core_q.bk_s2 |=> sink_output == '0 && core_q.cnt == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking did not clear"); // [R7]

  property p_pwm;
    @(posedge mclk) disable iff (!nrst)
    !core_q.bk_s2 && !core_q.hold |=> sink_output[0] == ($past(core_q.cnt) < $past(core_q.gs[0]));
  endproperty
  a_pwm: assert property (p_pwm) else $error("channel 0 PWM mismatch"); // [R8]

  property p_stag;
    @(posedge mclk) disable iff (!nrst)
    per_start |=> !sink_output[1] && !sink_output[2] ##1 !sink_output[3];
  endproperty
  a_stag: assert property (p_stag) else $error("group turned on too early"); // [R9]

  property p_wrap;
    @(posedge mclk) disable iff (!nrst)
    per_start && !core_q.bk_s2 |=> core_q.cnt == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // [R11]

  property p_stag_start;
    @(posedge mclk) disable iff (!nrst)
    core_q.stag == '0 |=> (sink_output[3:1] == '0) ##1 (sink_output[3:2] == '0) ##1 !sink_output[3];
  endproperty
  a_stag_start: assert property (p_stag_start) else $error("group on before its stagger delay"); // [R9]

  property p_gs_hold;
    @(posedge mclk) disable iff (!nrst)
    !core_q.hold |=> $stable(core_q.gs);
  endproperty
  a_gs_hold: assert property (p_gs_hold) else $error("display latch changed while shown"); // [R4]

  property p_load_hold;
    @(posedge mclk) disable iff (!nrst)
    core_q.ld == sgp_pkg::SGP_LOAD |=> core_q.hold;
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("outputs released during load"); // [R5]

  property p_blank_init;
    @(posedge mclk) disable iff (!nrst)
    core_q.bk_s2 |=> core_q.stag == '0 && !core_q.tick && core_q.acc == '0;
  endproperty
  a_blank_init: assert property (p_blank_init) else $error("blanking did not reset timing"); // [R7]

  property p_cnt_hold;
    @(posedge mclk) disable iff (!nrst)
    !core_q.bk_s2 && !core_q.tick |=> core_q.cnt == $past(core_q.cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without a tick"); // [R11]

  property p_cnt_step;
    @(posedge mclk) disable iff (!nrst)
    !core_q.bk_s2 && core_q.tick |=> core_q.cnt == $past(core_q.cnt) + 1'b1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step on a tick"); // [R11]

  property p_tick_gap;
    @(posedge mclk) disable iff (!nrst)
    core_q.tick |=> (!core_q.tick) [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("oscillator ticks too close"); // [R11]
endmodule

// ===== inc/sgp_cfg.svh
// Constants for the serial grayscale PWM driver
`ifndef SGP_CFG_SVH
`define SGP_CFG_SVH
`define SGP_CH 24
`define SGP_GSW 12
`define SGP_SRW 288
`define SGP_CHW 5
`define SGP_LAST_CH 5'h17
`define SGP_CNT_MAX 12'hFFF
`define SGP_MCLK_NS 20
`define SGP_MCLK_KHZ 50000
`define SGP_OSC_KHZ 4000
`define SGP_ACCW 16
`define SGP_GRP1_NS 24
`define SGP_GRP2_NS 48
`define SGP_GRP3_NS 72
`define SGP_STAGW 3
`define SGP_LATCH_GUARD_NS 100
`define SGP_FIFO_DEPTH 8
`endif

// ===== inc/sgp_pkg.sv
// Types shared by the serial grayscale PWM driver
`include "sgp_cfg.svh"
package sgp_pkg;
  // Loader state, one-hot
  typedef enum logic [1:0] {
    SGP_IDLE = 2'b01,
    SGP_LOAD = 2'b10
  } sgp_ld_t;

  // One channel update travelling through the FIFO
  typedef struct packed {
    logic [`SGP_CHW-1:0] ch;
    logic [`SGP_GSW-1:0] gs;
  } sgp_word_t;

  // State clocked by the shift clock
  typedef struct packed {
    logic [`SGP_SRW-1:0] shreg;
  } sgp_link_t;

  // State clocked by mclk
  typedef struct packed {
    logic xl_s1;
    logic xl_s2;
    logic xl_s3;
    logic bk_s1;
    logic bk_s2;
    logic [`SGP_CH-1:0][`SGP_GSW-1:0] snap;
    sgp_ld_t ld;
    logic [`SGP_CHW-1:0] idx;
    logic [`SGP_ACCW-1:0] acc;
    logic tick;
    logic [`SGP_GSW-1:0] cnt;
    logic hold;
    logic [`SGP_STAGW-1:0] stag;
    logic [`SGP_CH-1:0][`SGP_GSW-1:0] gs;
    logic [`SGP_CH-1:0] sink;
  } sgp_core_t;
endpackage

// ===== verilog/sgp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sgp_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [W-1:0] in_data, // Write word
  output logic out_valid, // Word available
  input wire logic out_ready, // Read request
  output logic [W-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sgp_fifo_st_t;

  sgp_fifo_st_t st_q;
  sgp_fifo_st_t st_d;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign empty = (st_q.wp == st_q.rp);
  assign full = (st_q.wp[AW] != st_q.rp[AW]) && (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_q.mem[st_q.rp[AW-1:0]];

  // Pointer and storage update
  always_comb begin
    st_d = st_q;
    if (in_valid && !full) begin
      st_d.mem[st_q.wp[AW-1:0]] = in_data;
      st_d.wp = st_q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      st_d.rp = st_q.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ===== bench/sgp_host_model.sv
// Host controller model: shifts frames out on its own link clock
`timescale 1ns/100ps
`include "sgp_cfg.svh"
module sgp_host_model (
  output logic shift_clock, // Link clock, still between frames
  output logic serial_in, // Data into the driver
  input wire logic serial_out, // Cascade data from the driver
  output logic [`SGP_SRW-1:0] echo // Bits seen on serial_out, newest at bit 0
);
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    echo = '0;
  end
  // MSB first; data moves while the clock is low so each rise samples settled data
  task automatic send(input logic [`SGP_SRW-1:0] frame);
    for (int i = `SGP_SRW - 1; i >= 0; i--) begin
      serial_in = frame[i];
      #23 shift_clock = 1'b1;
      #24 shift_clock = 1'b0;
      #1 echo = {echo[`SGP_SRW-2:0], serial_out};
    end
    // Line no longer valid after the frame, so it shows the inverse
    serial_in = ~serial_in;
  endtask
endmodule

// ===== bench/sgp_driver_tb_top.sv
// Self-checking bench for the serial grayscale PWM driver
`timescale 1ns/100ps
`include "sgp_cfg.svh"
module sgp_driver_tb_top;
  logic mclk;
  logic nrst;
  logic latch_strobe;
  logic output_blanking;
  wire shift_clock;
  wire serial_in;
  wire serial_out;
  wire [`SGP_CH-1:0] sink_output;
  wire [`SGP_SRW-1:0] echo;
  logic [`SGP_SRW-1:0] ramp;
  logic [`SGP_SRW-1:0] alt;
  int mismatches;
  int check_count;

  sgp_driver uut (
    .mclk(mclk),
    .nrst(nrst),
    .shift_clock(shift_clock),
    .serial_in(serial_in),
    .latch_strobe(latch_strobe),
    .output_blanking(output_blanking),
    .serial_out(serial_out),
    .sink_output(sink_output)
  );

  sgp_host_model host (
    .shift_clock(shift_clock),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .echo(echo)
  );

  // 50 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [`SGP_SRW-1:0] seen, input logic [`SGP_SRW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Pulse long enough for the 2-ff sync, then keep the link quiet past the guard time
  task automatic pulse_latch;
    @(negedge mclk) latch_strobe = 1'b1;
    repeat (3) @(negedge mclk);
    latch_strobe = 1'b0;
    repeat (10) @(negedge mclk);
  endtask

  // Old frame must come out from bit 286 down while the new one goes in, then the new MSB follows
  task automatic test_shift_echo;
    host.send(alt);
    host.send(ramp);
    check("echo", echo, {alt[`SGP_SRW-2:0], ramp[`SGP_SRW-1]});
    $display("test shift_echo done");
  endtask

  // Wait a bounded time for channel 0, then groups 1..3 must follow one cycle apart
  task automatic stagger_walk(input string what, input int limit);
    logic [`SGP_SRW-1:0] exp;
    int w;
    w = 0;
    while (sink_output[0] !== 1'b1 && w < limit) begin
      @(negedge mclk);
      w++;
    end
    for (int k = 0; k < 4; k++) begin
      exp = '0;
      for (int n = 0; n < `SGP_CH; n++) begin
        exp[n] = ((n % 4) <= k);
      end
      check(what, sink_output, exp);
      @(negedge mclk);
    end
  endtask

  // Blanking, restart from zero, staggered turn-on and the duty per channel
  task automatic test_pwm;
    pulse_latch();
    // Blank long enough for the whole load to drain before release
    @(negedge mclk) output_blanking = 1'b1;
    repeat (40) @(negedge mclk);
    check("blank_off", sink_output, '0);
    output_blanking = 1'b0;
    stagger_walk("stagger", 30);
    // Counter should sit at 7 here, so channels with value 8 and up still conduct
    repeat (90) @(negedge mclk);
    check("duty", sink_output, 24'hFFFF80);
    // Blanking mid-period kills the sinks; channel 0 (value 1) returns only if the counter restarts
    output_blanking = 1'b1;
    repeat (4) @(negedge mclk);
    check("blank_mid", sink_output, '0);
    output_blanking = 1'b0;
    stagger_walk("restart", 30);
    $display("test pwm done");
  endtask

  // A new latch while sinks conduct forces them all off and keeps them off
  task automatic test_latch_off;
    host.send(alt);
    @(negedge mclk) output_blanking = 1'b1;
    repeat (4) @(negedge mclk);
    output_blanking = 1'b0;
    stagger_walk("relatch_run", 30);
    pulse_latch();
    check("latch_off", sink_output, '0);
    repeat (100) @(negedge mclk);
    check("latch_hold", sink_output, '0);
    $display("test latch_off done");
  endtask

  // Held sinks return at the next period start, now driven by the new latch contents
  task automatic test_period;
    stagger_walk("period_start", 53000);
    // Counter near 32: the new value 5A3 conducts everywhere, the old ramp nowhere
    repeat (400) @(negedge mclk);
    check("new_duty", sink_output, 24'hFFFFFF);
    $display("test period done");
  endtask

  // Watchdog sized past three frames plus one full PWM period of about 1.02 ms
  initial begin
    #1300000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    latch_strobe = 1'b0;
    output_blanking = 1'b0;
    mismatches = 0;
    check_count = 0;
    for (int n = 0; n < `SGP_CH; n++) begin
      ramp[n*`SGP_GSW +: `SGP_GSW] = 12'(n + 1);
      alt[n*`SGP_GSW +: `SGP_GSW] = 12'h5A3;
    end
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    check("reset_sinks", sink_output, '0);
    test_shift_echo();
    test_pwm();
    test_latch_off();
    test_period();
    tally_and_finish();
  end
endmodule
